/* File: common/clkbuf_defines.svh */
// Constants for the clock buffer power and serial control block.
// Assumes a 200 MHz system clock; included by its bare name.
`ifndef CLKBUF_DEFINES_SVH
`define CLKBUF_DEFINES_SVH

`define SYS_CLK_PERIOD_NS 5.0
`define SEQ_DELAY_MIN_MS 0.1
`define SEQ_DELAY_MAX_MS 0.3
`define POWER_UP_MAX_MS 1.8

`define REG_CTRL0_IDX 8'h00
`define REG_BYTE_COUNT_IDX 8'h07

`define CTRL0_MODE_HI 7
`define CTRL0_MODE_LO 6
`define CTRL0_EN_HI 5
`define CTRL0_EN_LO 3
`define CTRL0_FSEL 0
`define BC_HI 4

`define OUT_EN_RST 3'h7
`define BYTE_COUNT_RST 5'h08
`define STRAP_LOW 2'h0
`define STRAP_MID 2'h1
`define STRAP_HIGH 2'h2

`endif

/* File: common/clkbuf_pkg.sv */
// Types for the clock buffer power and serial control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package clkbuf_pkg;

  typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_WAIT, SEQ_RUN} seq_type;

  typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_RACK, BUS_TX, BUS_TACK} bus_type;

  typedef enum logic [1:0] {STEP_ADDR, STEP_INDEX, STEP_COUNT, STEP_DATA} step_type;

endpackage : clkbuf_pkg
`default_nettype wire

/* File: hw/clock_buffer_smbus_power_ctrl.sv */
// Power pin handling, power-up sequencer and serial slave of a clock buffer.
// Assumes all pin and analog inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "clkbuf_defines.svh"

// Behaviour
// - first rise of power pin latches frequency, bandwidth and address straps.
// - after first rise the pin acts as active-low power-down.
// - low over two complement rises stops outputs at next complement fall.
// - on valid supply leave off state, wait at least 0.1 ms.
// - second state waits for reference clock and power pin high.
// - outputs enabled in state three only after PLL lock.
// - power-on to outputs active under 1.8 ms with clock present.
// - no reference clock keeps every output disabled.
// - block write: address, index, count, data bytes, each acknowledged.
// - indexed read: index write, repeated start, count then data.
// - host ends read with not-acknowledge; device releases data line.
// - answer only to the address chosen by latched straps.
// - control byte zero reads latched mode, frequency; bit two zero.
// - control byte zero bits five to three enable top outputs.
// - byte count register defaults to eight, reported on read.
module clock_buffer_smbus_power_ctrl
  import clkbuf_pkg::*;
#(
  parameter logic [6:0] ADDR_BASE = 7'h60,
  parameter int DELAY_CYC = int'(`SEQ_DELAY_MIN_MS * 1.0e6 / `SYS_CLK_PERIOD_NS)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic power_good_or_down_pin,
  input wire logic frequency_select_strap,
  input wire logic [1:0] pll_bandwidth_strap,
  input wire logic [3:0] slave_address_strap,
  input wire logic supply_valid,
  input wire logic ref_clk_valid,
  input wire logic pll_locked,
  input wire logic clock_out_comp,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic outputs_run,
  output logic [2:0] out_high_enable
);

  localparam int NSYNC = 14;
  logic [NSYNC-1:0] sync1_r, sync2_r;
  logic pin_s, fsel_s, scl_s, sda_s, comp_s, supply_s, ref_s, lock_s;
  logic [1:0] bw_s;
  logic [3:0] sa_s;

  // Two-flop synchronisers; serial lines reset to their idle high level
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 14'h0030;
      sync2_r <= 14'h0030;
    end else begin
      sync1_r <= {power_good_or_down_pin, frequency_select_strap, pll_bandwidth_strap,
                  slave_address_strap, scl_in, sda_in, clock_out_comp, supply_valid,
                  ref_clk_valid, pll_locked};
      sync2_r <= sync1_r;
    end
  end

  assign {pin_s, fsel_s, bw_s, sa_s, scl_s, sda_s, comp_s, supply_s, ref_s, lock_s} = sync2_r;

  // Edge history
  logic pin_d_r, comp_d_r, scl_d_r, sda_d_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_d_r <= 1'b0;
      comp_d_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      pin_d_r <= pin_s;
      comp_d_r <= comp_s;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  wire comp_rise = comp_s & ~comp_d_r;
  wire comp_fall = ~comp_s & comp_d_r;
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Strap capture on first power-good rise
  logic pg_seen_r, fsel_r;
  logic [1:0] mode_r, mode_nxt;
  logic [3:0] sa_r;
  wire first_rise = pin_s & ~pin_d_r & ~pg_seen_r;
  assign mode_nxt = (bw_s == `STRAP_LOW) ? 2'h0 : (bw_s == `STRAP_MID) ? 2'h1 : 2'h3;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pg_seen_r <= 1'b0;
      fsel_r <= 1'b0;
      mode_r <= 2'h0;
      sa_r <= 4'h0;
    end else if (first_rise) begin
      pg_seen_r <= 1'b1;
      fsel_r <= fsel_s;
      mode_r <= mode_nxt;
      sa_r <= sa_s;
    end
  end

  // Power-down: count complement rises while low
  logic [1:0] pd_cnt_r;
  logic stopped_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pd_cnt_r <= 2'h0;
      stopped_r <= 1'b0;
    end else if (pin_s || !pg_seen_r) begin
      pd_cnt_r <= 2'h0;
      stopped_r <= 1'b0;
    end else begin
      if (comp_rise && pd_cnt_r != 2'h2) begin
        pd_cnt_r <= pd_cnt_r + 2'h1;
      end
      if (comp_fall && pd_cnt_r == 2'h2) begin
        stopped_r <= 1'b1;
      end
    end
  end

  // Power-up sequencer
  seq_type seq_r;
  logic [31:0] dly_cnt_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seq_r <= SEQ_OFF;
      dly_cnt_r <= '0;
    end else if (!supply_s) begin
      seq_r <= SEQ_OFF;
      dly_cnt_r <= '0;
    end else begin
      case (seq_r)
        SEQ_OFF: begin
          seq_r <= SEQ_DELAY;
          dly_cnt_r <= '0;
        end
        SEQ_DELAY: begin
          dly_cnt_r <= dly_cnt_r + 32'h1;
          if (dly_cnt_r == 32'(DELAY_CYC - 1)) begin
            seq_r <= SEQ_WAIT;
          end
        end
        SEQ_WAIT: begin
          if (ref_s && pin_s && lock_s) begin
            seq_r <= SEQ_RUN;
          end
        end
        default: seq_r <= SEQ_RUN;
      endcase
    end
  end

  // Output gating
  logic [2:0] en_r;
  logic run_nxt;
  assign run_nxt = (seq_r == SEQ_RUN) && ref_s && !stopped_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      outputs_run <= 1'b0;
      out_high_enable <= 3'h0;
      sda_out <= 1'b0;
    end else begin
      outputs_run <= run_nxt;
      out_high_enable <= run_nxt ? en_r : 3'h0;
      sda_out <= 1'b0;
    end
  end

  // Serial slave
  bus_type bus_r;
  step_type step_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r, tx_r, index_r, ctrl0, rd_data;
  logic [4:0] bc_r;
  logic read_r, nack_r;
  logic [6:0] my_addr;
  assign my_addr = ADDR_BASE + 7'(sa_r[3:2]) * 7'h03 + 7'(sa_r[1:0]);
  assign ctrl0 = {mode_r, en_r, 1'b0, 1'b0, fsel_r};
  assign rd_data = (index_r == `REG_CTRL0_IDX) ? ctrl0 :
                   (index_r == `REG_BYTE_COUNT_IDX) ? {3'h0, bc_r} : 8'h00;
  wire addr_hit = shift_r[7:1] == my_addr;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bus_r <= BUS_IDLE;
      step_r <= STEP_ADDR;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      index_r <= 8'h00;
      read_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      bus_r <= BUS_RX;
      step_r <= STEP_ADDR;
      cnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      bus_r <= BUS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (bus_r)
        BUS_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            if (step_r == STEP_ADDR && !addr_hit) begin
              bus_r <= BUS_IDLE;
            end else begin
              bus_r <= BUS_RACK;
              sda_oe <= 1'b1;
              if (step_r == STEP_ADDR) begin
                read_r <= shift_r[0];
              end
              if (step_r == STEP_INDEX) begin
                index_r <= shift_r;
              end
              if (step_r == STEP_DATA) begin
                index_r <= index_r + 8'h01;
              end
            end
          end
        end
        BUS_RACK: begin
          if (scl_fall) begin
            if (step_r == STEP_ADDR && read_r) begin
              tx_r <= {3'h0, bc_r};
              sda_oe <= 1'b1; // Count byte MSB is always zero
              bus_r <= BUS_TX;
            end else begin
              sda_oe <= 1'b0;
              bus_r <= BUS_RX;
              step_r <= (step_r == STEP_DATA) ? STEP_DATA : step_type'(step_r + 2'h1);
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              sda_oe <= 1'b0;
              cnt_r <= 4'h0;
              bus_r <= BUS_TACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe <= ~tx_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        BUS_TACK: begin
          if (scl_rise) begin
            nack_r <= sda_s;
          end else if (scl_fall) begin
            if (nack_r) begin
              bus_r <= BUS_IDLE;
            end else begin
              tx_r <= rd_data;
              sda_oe <= ~rd_data[7];
              index_r <= index_r + 8'h01;
              bus_r <= BUS_TX;
            end
          end
        end
        default: sda_oe <= 1'b0;
      endcase
    end
  end

  // Register writes from block write data bytes
  wire wr_data = (bus_r == BUS_RX) && scl_fall && cnt_r == 4'h8 && step_r == STEP_DATA;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= `OUT_EN_RST;
      bc_r <= `BYTE_COUNT_RST;
    end else if (wr_data && index_r == `REG_CTRL0_IDX) begin
      en_r <= shift_r[`CTRL0_EN_HI:`CTRL0_EN_LO];
    end else if (wr_data && index_r == `REG_BYTE_COUNT_IDX) begin
      bc_r <= shift_r[`BC_HI:0];
    end
  end

  // Checks
  AST_STRAP_LATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
    first_rise |=> fsel_r == $past(fsel_s) && sa_r == $past(sa_s) && pg_seen_r)
    else $error("straps not latched on first power-good rise");
  AST_PD_STOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    pg_seen_r && !pin_s && pd_cnt_r == 2'h2 && comp_fall |=> ##1 !outputs_run)
    else $error("outputs still running after power-down");
  AST_DELAY_MIN: assert property (@(posedge sys_clk) disable iff (!nrst)
    seq_r == SEQ_DELAY && dly_cnt_r < 32'(DELAY_CYC - 1) |=> seq_r != SEQ_WAIT)
    else $error("delay state left early");
  AST_WAIT_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
    seq_r == SEQ_WAIT && !(ref_s && pin_s) |=> seq_r != SEQ_RUN)
    else $error("run entered without clock and power pin");
  AST_LOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(seq_r == SEQ_RUN) |-> $past(lock_s))
    else $error("run entered without lock");
  AST_NO_CLK: assert property (@(posedge sys_clk) disable iff (!nrst)
    !ref_s |=> !outputs_run && out_high_enable == 3'h0)
    else $error("outputs enabled without reference clock");
  AST_ACK: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus_r == BUS_RX && scl_fall && cnt_r == 4'h8 && step_r != STEP_ADDR && !bus_start
    && !bus_stop |=> sda_oe && bus_r == BUS_RACK)
    else $error("byte not acknowledged");
  AST_NACK_END: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus_r == BUS_TACK && nack_r && scl_fall && !bus_start && !bus_stop
    |=> bus_r == BUS_IDLE && !sda_oe)
    else $error("data line driven after not-acknowledge");
  AST_ADDR_MISS: assert property (@(posedge sys_clk) disable iff (!nrst)
    bus_r == BUS_RX && step_r == STEP_ADDR && scl_fall && cnt_r == 4'h8 && !addr_hit
    && !bus_start && !bus_stop |=> bus_r == BUS_IDLE && !sda_oe)
    else $error("answered a foreign address");
  AST_EN_GATE: assert property (@(posedge sys_clk) disable iff (!nrst)
    out_high_enable != 3'h0 |-> (out_high_enable & ~$past(en_r)) == 3'h0)
    else $error("output enabled against its enable bit");
  AST_IDX_STEP: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_data && !bus_start && !bus_stop |=> index_r == $past(index_r) + 8'h01)
    else $error("index did not advance");
endmodule : clock_buffer_smbus_power_ctrl
`default_nettype wire

/* File: dv/smbus_host_model.sv */
// SMBus host model: start, repeated start, stop, byte send and receive.
// Assumes the bench resolves the pulled-up data line; scl is driven directly.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output var logic scl,
  output var logic host_sda_oe
);
  initial begin
    scl = 1'b1;
    host_sda_oe = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // Data moves only while scl is low
  task automatic put_bit(input logic b);
    scl = 1'b0;
    cyc(4);
    host_sda_oe = ~b;
    cyc(4);
    scl = 1'b1;
    cyc(8);
  endtask : put_bit
  task automatic start();
    host_sda_oe = 1'b1;
    cyc(10);
  endtask : start
  task automatic rstart();
    scl = 1'b0;
    cyc(5);
    host_sda_oe = 1'b0;
    cyc(5);
    scl = 1'b1;
    cyc(10);
    host_sda_oe = 1'b1;
    cyc(10);
  endtask : rstart
  task automatic stop();
    scl = 1'b0;
    cyc(5);
    host_sda_oe = 1'b1;
    cyc(5);
    scl = 1'b1;
    cyc(10);
    host_sda_oe = 1'b0;
    cyc(10);
  endtask : stop
  task automatic send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    put_bit(1'b1);
    ack = ~sda_line;
  endtask : send_byte
  // Ack each byte, not-acknowledge on the last
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1);
      d[i] = sda_line;
    end
    put_bit(~ack);
  endtask : recv_byte
endmodule : smbus_host_model
`default_nettype wire

/* File: dv/clock_buffer_smbus_power_ctrl_bench.sv */
// Bench for the clock buffer power and serial control block.
// Assumes the host model file; data line pulled up, comp clock 80 ns.
`timescale 1ns/1ps
`default_nettype none
module clock_buffer_smbus_power_ctrl_bench;
  import clkbuf_pkg::*;
  localparam int DLY = 20;
  localparam logic [6:0] ADDR = 7'h65;
  logic sys_clk, nrst, pin, fsel, sup, refv, lock, comp, ack;
  logic [1:0] bw;
  logic [3:0] sa;
  logic sda_out, sda_oe, outputs_run;
  logic [2:0] out_high_enable;
  logic [7:0] rcnt;
  logic [7:0] rbuf [8];
  wire logic scl;
  wire logic host_oe;
  wire logic sda_line = host_oe ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  int num_errors = 0;
  int total_checks = 0;
  clock_buffer_smbus_power_ctrl #(.ADDR_BASE(7'h60), .DELAY_CYC(DLY))
    clock_buffer_smbus_power_ctrl_i (
    .sys_clk(sys_clk), .nrst(nrst), .power_good_or_down_pin(pin),
    .frequency_select_strap(fsel), .pll_bandwidth_strap(bw), .slave_address_strap(sa),
    .supply_valid(sup), .ref_clk_valid(refv), .pll_locked(lock), .clock_out_comp(comp),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .outputs_run(outputs_run), .out_high_enable(out_high_enable));
  smbus_host_model smbus_host_model_i (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl),
    .host_sda_oe(host_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    comp = 1'b0;
    forever #40 comp = ~comp;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #400us;
    num_errors++;
    $display("Error watchdog expected done seen timeout");
    finish_test();
  end
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic wait_run(input logic v, input int lim, output int n);
    n = 0;
    while (outputs_run !== v && n < lim) begin
      cyc(1);
      n++;
    end
  endtask : wait_run
  task automatic tx(input logic [7:0] d);
    smbus_host_model_i.send_byte(d, ack);
    check("ack", 8'h01, {7'h00, ack});
  endtask : tx
  task automatic wr(input logic [7:0] idx, input logic [7:0] d0, input logic [7:0] d1,
                    input logic [7:0] cnt);
    smbus_host_model_i.start();
    tx({ADDR, 1'b0});
    tx(idx);
    tx(cnt);
    tx(d0);
    if (cnt == 8'h02) tx(d1);
    smbus_host_model_i.stop();
  endtask : wr
  task automatic rd(input logic [7:0] idx, input int n);
    smbus_host_model_i.start();
    tx({ADDR, 1'b0});
    tx(idx);
    smbus_host_model_i.rstart();
    tx({ADDR, 1'b1});
    smbus_host_model_i.recv_byte(1'b1, rcnt);
    for (int i = 0; i < n; i++) begin
      smbus_host_model_i.recv_byte(i < n - 1, rbuf[i]);
    end
    smbus_host_model_i.stop();
    cyc(5);
    check("sda_released", 8'h00, {7'h00, sda_oe});
  endtask : rd
  task automatic t_power_up();
    int n;
    sup = 1'b1;
    cyc(100);
    check("run_no_pgood", 8'h00, {7'h00, outputs_run});
    pin = 1'b1;
    cyc(20);
    fsel = 1'b0;
    bw = 2'h2;
    sa = 4'h0;
    cyc(100);
    check("run_no_ref", 8'h00, {7'h00, outputs_run});
    refv = 1'b1;
    cyc(100);
    check("run_no_lock", 8'h00, {7'h00, outputs_run});
    lock = 1'b1;
    wait_run(1'b1, 20, n);
    check("run_locked", 8'h01, {7'h00, outputs_run});
  endtask : t_power_up
  task automatic t_power_down();
    int n;
    pin = 1'b0;
    cyc(8);
    check("run_early", 8'h01, {7'h00, outputs_run});
    wait_run(1'b0, 80, n);
    check("run_stopped", 8'h00, {7'h00, outputs_run});
    check("stop_late", 8'h01, {7'h00, n >= 16});
    pin = 1'b1;
    wait_run(1'b1, 10, n);
    check("run_resumed", 8'h01, {7'h00, outputs_run});
  endtask : t_power_down
  task automatic t_supply_cycle();
    int n;
    sup = 1'b0;
    wait_run(1'b0, 10, n);
    check("run_supply_off", 8'h00, {7'h00, outputs_run});
    sup = 1'b1;
    wait_run(1'b1, DLY + 20, n);
    check("delay_min", 8'h01, {7'h00, n >= DLY});
    check("delay_max", 8'h01, {7'h00, outputs_run});
  endtask : t_supply_cycle
  task automatic t_read_regs();
    rd(8'h00, 8);
    check("count", 8'h08, rcnt);
    check("byte0", 8'h79, rbuf[0]);
    for (int i = 1; i < 7; i++) begin
      check("unmapped", 8'h00, rbuf[i]);
    end
    check("byte7", 8'h08, rbuf[7]);
  endtask : t_read_regs
  task automatic t_write_regs();
    wr(8'h00, 8'h00, 8'h00, 8'h01);
    cyc(5);
    check("enables_off", 8'h00, {5'h00, out_high_enable});
    wr(8'h06, 8'hff, 8'h05, 8'h02);
    rd(8'h06, 2);
    check("count_new", 8'h05, rcnt);
    check("byte6", 8'h00, rbuf[0]);
    check("byte7_new", 8'h05, rbuf[1]);
    wr(8'h00, 8'hd6, 8'h00, 8'h01);
    cyc(5);
    check("enables_mix", 8'h02, {5'h00, out_high_enable});
    rd(8'h00, 1);
    check("byte0_ro", 8'h51, rbuf[0]);
  endtask : t_write_regs
  task automatic t_wrong_addr();
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({7'h60, 1'b0}, ack);
    check("ack_wrong", 8'h00, {7'h00, ack});
    smbus_host_model_i.stop();
    check("sda_idle", 8'h00, {7'h00, sda_oe});
  endtask : t_wrong_addr
  initial begin
    nrst = 1'b0;
    pin = 1'b0;
    fsel = 1'b1;
    bw = 2'h1;
    sa = 4'h6;
    sup = 1'b0;
    refv = 1'b0;
    lock = 1'b0;
    cyc(16);
    nrst = 1'b1;
    cyc(4);
    t_power_up();
    t_power_down();
    t_supply_cycle();
    t_read_regs();
    t_write_regs();
    t_wrong_addr();
    pin = 1'b0;
    cyc(40);
    refv = 1'b0;
    cyc(10);
    finish_test();
  end
endmodule : clock_buffer_smbus_power_ctrl_bench
`default_nettype wire
